// ### lpeh_asserts.sv
// Checker of the controller link
`timescale 1ns/1ps
`default_nettype none
module lpeh_asserts
  import lpeh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic entryStrobe,
  input wire lpeh_mode_t targetMode,
  input wire logic irqStrobe,
  input wire logic converterClkReq,
  input wire logic serialClkReq,
  input wire logic cpuClkReq,
  input wire logic subsysClkReq,
  input wire logic subsysFreqDiffers,
  input wire logic groupAActive,
  input wire logic groupBActive,
  input wire logic pucStrobe,
  input wire logic borStrobe,
  input wire logic powerCycleStrobe,
  input wire logic regWrite,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire lpeh_mode_t powerMode,
  input wire lpeh_fault_t faultState,
  input wire logic nvmPowered,
  input wire logic debugPullDown
);
  logic quiet; // No reset strobe
  logic calmEntry; // Deep entry, irq, no clock
  logic runLpm3; // Wake irq in mode 3
  assign quiet = !pucStrobe && !borStrobe && !powerCycleStrobe;
  assign calmEntry = quiet && faultState == LPEH_RUN && powerMode == LPEH_AM && entryStrobe && irqStrobe
    && targetMode inside {LPEH_LPM2, LPEH_LPM3, LPEH_LPM4} && !converterClkReq && !serialClkReq
    && !cpuClkReq && !subsysClkReq && nvmPowered;
  assign runLpm3 = quiet && faultState == LPEH_RUN && powerMode == LPEH_LPM3 && irqStrobe;

  // All checks share one clock; reset silences them
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Oscillator steady: only the second hazard
  chk_lock_two: assert property (
    calmEntry && subsysFreqDiffers && $stable(converterClkReq) && $stable(serialClkReq) |=> faultState == LPEH_LOCK_TWO)
    else $error("no lock two");
  chk_same_freq: assert property (
    calmEntry && !subsysFreqDiffers && $stable(converterClkReq) && $stable(serialClkReq) |=> faultState == LPEH_RUN)
    else $error("lock at same freq");
  chk_puc_keeps_two: assert property (
    faultState == LPEH_LOCK_TWO && pucStrobe && !borStrobe && !powerCycleStrobe |=> faultState == LPEH_LOCK_TWO)
    else $error("clear left lock two");
  // Brownout restores all
  chk_bor_clears: assert property (
    borStrobe || powerCycleStrobe |=> faultState == LPEH_RUN && powerMode == LPEH_AM && nvmPowered && debugPullDown)
    else $error("no restore");
  chk_wake_hang: assert property (
    runLpm3 && groupAActive != groupBActive |=> faultState == LPEH_WAKE_HANG)
    else $error("no wake hang");
  chk_wake_ok: assert property (
    runLpm3 && groupAActive == groupBActive |=> powerMode == LPEH_AM ##0 faultState == LPEH_RUN)
    else $error("wake failed");
  chk_debug_pull: assert property (
    quiet && faultState == LPEH_RUN && regWrite && regAddr == LPEH_REG_RSTPIN
    |=> debugPullDown == $past(regWdata[LPEH_RST_RESEN_BIT]))
    else $error("pull-down mismatch");
  // Memory bits written only right after unlock
  chk_unlock_first: assert property (
    regWrite && regAddr == LPEH_REG_GENERAL
    |-> $past(regWrite) && $past(regAddr) == LPEH_REG_LOCK && $past(regWdata[15:8]) == LPEH_NVM_PASSWORD)
    else $error("write while locked");

  // Main scenarios reached
  cover property (calmEntry && subsysFreqDiffers);
  cover property (faultState == LPEH_WAKE_HANG);
  cover property (regWrite && regAddr == LPEH_REG_GENERAL);
endmodule : lpeh_asserts
`default_nettype wire

// ### lpeh_device.sv
// Power-mode controller end with entry hazards
//
// Operation
// (R1) Entry, interrupt, oscillator clock change: lockup
// (R2) Only converter and serial request oscillator clock; here cpuClkReq also holds the oscillator clock running
// (R3) Processor-started clock events never trigger lockup
// (R4) First lockup left by clear, brownout, cycle
// (R5) Entry, interrupt, no clocks running: second lockup
// (R6) Second lockup needs differing subsystem frequency
// (R7) Second lockup left only by brownout, cycle
// (R8) Software prefers modes 0, 1, x.5
// (R9) Software powers down memory before deep entry
// (R10) Software unlocks with password, relocks before entry
// (R11) Mode 3 with one group: wake-up hang
// (R12) Software enables both groups in mode 3
// (R13) Software may use modes up to 2 instead
// (R14) Resistor enable cleared drops debug pin pull-down
// (R15) Software keeps resistor enable, uses pull direction
`timescale 1ns/1ps
`default_nettype none
module lpeh_device
  import lpeh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  lpeh_if.device link,
  output var lpeh_mode_t powerModeOut,
  output var lpeh_fault_t faultOut,
  output var logic debugExposed
);

  // Whole controller state
  typedef struct packed
  {
    lpeh_mode_t mode; // Present power mode
    lpeh_fault_t fault; // Present fault condition
    logic [1:0] gen; // Memory power bits
    logic [1:0] rstPin; // Reset pin resistor enable and direction
    logic unlocked; // Memory control unlocked by password
    logic prevConv; // Converter request one cycle ago
    logic prevSerial; // Serial request one cycle ago
    logic exposed; // Debug pin left floating
  } lpeh_dev_state_t;

  lpeh_dev_state_t state; // Registered state
  lpeh_dev_state_t next_state; // Next value

  logic convEvent; // Converter clock request toggled
  logic serialEvent; // Serial clock request toggled
  logic oscRunning; // Oscillator clock held by anyone
  logic nvmIdle; // Memory placed in its inactive state
  logic deepEntry; // Active-to-deep entry this cycle
  logic hazardOne; // First lockup condition met
  logic hazardTwo; // Second lockup condition met
  logic oneGroupOnly; // Exactly one peripheral group active

  // Hazard terms; all far-side inputs share this clock, so no synchroniser
  always_comb
  begin
    // Only the converter and serial unit produce asynchronous clock events
    convEvent = link.converterClkReq ^ state.prevConv; // [R2]
    serialEvent = link.serialClkReq ^ state.prevSerial; // [R2]

    // Processor requests run the clock, never an event
    oscRunning = link.converterClkReq | link.serialClkReq | link.cpuClkReq; // [R3]

    nvmIdle = (state.gen == 2'h0);

    deepEntry = link.entryStrobe && (state.fault == LPEH_RUN) && (state.mode == LPEH_AM)
                && lpeh_is_deep(link.targetMode);

    // Powered-down memory has nothing to corrupt, so the hazards vanish
    hazardOne = deepEntry && link.irqStrobe // [R1]
                && (convEvent || serialEvent) && !nvmIdle;

    hazardTwo = deepEntry && link.irqStrobe && !oscRunning && !link.subsysClkReq // [R5]
                && link.subsysFreqDiffers && !nvmIdle; // [R6]

    oneGroupOnly = link.groupAActive ^ link.groupBActive;
  end

  // Next state: resets, held fault, then normal work
  always_comb
  begin
    next_state = state;

    // Request history always follows, so events after recovery are fresh
    next_state.prevConv = link.converterClkReq;
    next_state.prevSerial = link.serialClkReq;

    if (link.borStrobe || link.powerCycleStrobe)
    begin
      // Brownout or supply cycle clears all
      next_state.mode = LPEH_AM; // [R4] [R7]
      next_state.fault = LPEH_RUN; // [R4] [R7]
      next_state.gen = LPEH_GEN_RESET;
      next_state.rstPin = LPEH_RSTPIN_RESET;
      next_state.unlocked = 1'b0;
    end

    else if (link.pucStrobe)
    begin
      // A clear recovers the first lockup and wake hang, not the second
      if (state.fault != LPEH_LOCK_TWO) // [R7]
      begin
        next_state.mode = LPEH_AM; // [R4]
        next_state.fault = LPEH_RUN; // [R4]
        next_state.gen = LPEH_GEN_RESET;
        next_state.unlocked = 1'b0;
      end
    end

    else if (state.fault != LPEH_RUN)
    begin
      // Locked: only resets act
      next_state.fault = state.fault;
    end
    else
    begin

      // Register port
      if (link.regWrite)
      begin
        case (link.regAddr)
          LPEH_REG_LOCK:
          begin
            // Key unlocks, anything else relocks
            next_state.unlocked = (link.regWdata[15:8] == LPEH_NVM_PASSWORD);
          end

          LPEH_REG_GENERAL:
          begin
            // Dropped unless unlocked
            if (state.unlocked)
            begin
              next_state.gen = link.regWdata[1:0];
            end
          end

          LPEH_REG_RSTPIN:
          begin
            next_state.rstPin = link.regWdata[1:0];
          end

          default:
          begin
            next_state.unlocked = state.unlocked;
          end
        endcase
      end

      // Power-mode sequencing
      if (hazardOne)
      begin
        next_state.fault = LPEH_LOCK_ONE; // [R1]
      end

      else if (hazardTwo)
      begin
        next_state.fault = LPEH_LOCK_TWO; // [R5]
      end

      else if (link.entryStrobe && (state.mode == LPEH_AM))
      begin
        // Shallow modes and x.5 never see the entry hazards
        next_state.mode = link.targetMode;
      end

      else if (link.irqStrobe && (state.mode != LPEH_AM))
      begin
        if ((state.mode == LPEH_LPM3) && oneGroupOnly)
        begin
          // One-group mode 3 wake stalls
          next_state.fault = LPEH_WAKE_HANG; // [R11]
        end
        else
        begin
          // Memory repowers on wake
          next_state.mode = LPEH_AM;
          next_state.gen = LPEH_GEN_RESET;
        end
      end
    end

    // Pull-down on the debug pin follows the resistor enable bit
    next_state.exposed = !next_state.rstPin[LPEH_RST_RESEN_BIT]; // [R14]
  end

  // State register; constants only under reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{mode: LPEH_AM, fault: LPEH_RUN, gen: LPEH_GEN_RESET,
                 rstPin: LPEH_RSTPIN_RESET, unlocked: 1'b0, prevConv: 1'b0,
                 prevSerial: 1'b0, exposed: 1'b0};
    end

    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign link.powerMode = state.mode;
  assign link.faultState = state.fault;
  assign link.nvmPowered = state.gen[LPEH_GEN_PWR_BIT];
  assign link.debugPullDown = !state.exposed; // [R14]
  assign link.resetPullUp = state.rstPin[LPEH_RST_PULLUP_BIT];

  assign powerModeOut = state.mode;
  assign faultOut = state.fault;
  assign debugExposed = state.exposed;

endmodule : lpeh_device
`default_nettype wire

// ### lpeh_host.sv
// Far-side end: AXI4-Lite controller and safe entry
`timescale 1ns/1ps
`default_nettype none
module lpeh_host
  import lpeh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  lpeh_if.host link,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output var logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  input wire logic arvalid,
  output var logic arready,
  input wire logic [3:0] araddr,
  output var logic rvalid,
  input wire logic rready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp
);

  // Safe entry sequence steps
  typedef enum logic [2:0]
  {
    LPEH_SEQ_IDLE = 3'h0,
    LPEH_SEQ_UNLOCK = 3'h1,
    LPEH_SEQ_CLEAR = 3'h2,
    LPEH_SEQ_RELOCK = 3'h3,
    LPEH_SEQ_ENTER = 3'h4
  } lpeh_seq_t;

  // Whole host state
  typedef struct packed
  {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic awHave; logic [3:0] awAddr; logic wHave; logic [31:0] wData; logic wLane;
    logic safeMode; logic [6:0] periph; lpeh_seq_t seq; lpeh_mode_t pendMode; logic pendIrq;
    logic entry; lpeh_mode_t target; logic irq; logic power_up_clear; logic bor; logic pcyc;
    logic regWrite; logic [1:0] regAddr; logic [15:0] regWdata;
  } lpeh_host_state_t;

  lpeh_host_state_t s; // Registered state
  lpeh_host_state_t next_s; // Next value
  lpeh_mode_t reqMode; // Mode after safe substitution

  // Bus slave, command decode and entry sequence
  always_comb
  begin
    next_s = s;
    reqMode = lpeh_mode_t'(s.wData[2:0]);
    // Strobes last one cycle
    next_s.entry = 1'b0; next_s.irq = 1'b0; next_s.power_up_clear = 1'b0;
    next_s.bor = 1'b0; next_s.pcyc = 1'b0; next_s.regWrite = 1'b0;
    // AW and W in either order
    if (awvalid && s.awready)
    begin
      next_s.awHave = 1'b1; next_s.awAddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.wHave = 1'b1; next_s.wData = wdata; next_s.wLane = wstrb[0];
    end
    if (bready && s.bvalid)
    begin
      next_s.bvalid = 1'b0;
    end
    // Both halves held: act and answer
    if (s.awHave && s.wHave && !s.bvalid)
    begin
      next_s.awHave = 1'b0; next_s.wHave = 1'b0; next_s.bvalid = 1'b1;
      next_s.bresp = LPEH_RESP_OKAY;
      // One-group mode 3 would hang on wake: use mode 2
      if (s.safeMode && (reqMode == LPEH_LPM3) && (s.periph[5] ^ s.periph[6]))
      begin
        reqMode = LPEH_LPM2; // [R12] [R13]
      end
      case (s.awAddr)
        LPEH_AXI_CTRL:
        begin
          if (s.wLane)
          begin
            next_s.safeMode = s.wData[8];
            next_s.power_up_clear = s.wData[5]; next_s.bor = s.wData[6]; next_s.pcyc = s.wData[7];
            if (s.wData[3] && (s.seq == LPEH_SEQ_IDLE))
            begin
              if (s.wData[8] && lpeh_is_deep(reqMode))
              begin
                // Deep entry only after memory sleeps
                next_s.seq = LPEH_SEQ_UNLOCK; // [R9]
                next_s.pendMode = reqMode; next_s.pendIrq = s.wData[4];
              end
              else
              begin
                // Shallow and x.5, or any mode without the safe bit, entered directly
                next_s.entry = 1'b1; next_s.target = reqMode; next_s.irq = s.wData[4]; // [R8]
              end
            end
            else
            begin
              next_s.irq = s.wData[4];
            end
          end
        end
        LPEH_AXI_PERIPH:
        begin
          if (s.wLane)
          begin
            next_s.periph = s.wData[6:0];
          end
        end
        LPEH_AXI_NVMWR:
        begin
          if (s.wLane && (s.seq == LPEH_SEQ_IDLE))
          begin
            next_s.regWrite = 1'b1; next_s.regAddr = s.wData[17:16];
            next_s.regWdata = s.wData[15:0];
            // Keep resistor enabled; direction picks the pull
            if (s.safeMode && (s.wData[17:16] == LPEH_REG_RSTPIN))
            begin
              next_s.regWdata[LPEH_RST_RESEN_BIT] = 1'b1; // [R15]
            end
          end
        end
        LPEH_AXI_STATUS: next_s.bresp = LPEH_RESP_OKAY;
        default: next_s.bresp = LPEH_RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.awHave && !next_s.bvalid;
    next_s.wready = !next_s.wHave && !next_s.bvalid;
    // Read channel: one read at a time
    if (rready && s.rvalid)
    begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1; next_s.rresp = LPEH_RESP_OKAY; next_s.rdata = 32'h0;
      case (araddr)
        LPEH_AXI_CTRL: next_s.rdata = {23'h0, s.safeMode, 8'h0};
        LPEH_AXI_PERIPH: next_s.rdata = {25'h0, s.periph};
        // Busy until the entry strobe has reached the device
        LPEH_AXI_STATUS: next_s.rdata = {23'h0, link.resetPullUp, link.debugPullDown, link.nvmPowered,
                                         link.faultState, link.powerMode, (s.seq != LPEH_SEQ_IDLE) || s.entry};
        LPEH_AXI_NVMWR: next_s.rdata = 32'h0;
        default: next_s.rresp = LPEH_RESP_SLVERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // Memory power-down, one write per cycle
    case (s.seq)
      LPEH_SEQ_IDLE: next_s.seq = next_s.seq;
      LPEH_SEQ_UNLOCK:
      begin
        next_s.regWrite = 1'b1; next_s.regAddr = LPEH_REG_LOCK; // [R10]
        next_s.regWdata = {LPEH_NVM_PASSWORD, 8'h00}; next_s.seq = LPEH_SEQ_CLEAR;
      end
      LPEH_SEQ_CLEAR:
      begin
        next_s.regWrite = 1'b1; next_s.regAddr = LPEH_REG_GENERAL; // [R9]
        next_s.regWdata = 16'h0000; next_s.seq = LPEH_SEQ_RELOCK;
      end
      LPEH_SEQ_RELOCK:
      begin
        next_s.regWrite = 1'b1; next_s.regAddr = LPEH_REG_LOCK; // [R10]
        next_s.regWdata = 16'h0000; next_s.seq = LPEH_SEQ_ENTER;
      end
      LPEH_SEQ_ENTER:
      begin
        next_s.entry = 1'b1; next_s.target = s.pendMode; next_s.irq = s.pendIrq | next_s.irq;
        next_s.seq = LPEH_SEQ_IDLE;
      end
      default: next_s.seq = LPEH_SEQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign awready = s.awready; assign wready = s.wready; assign bvalid = s.bvalid;
  assign bresp = s.bresp; assign arready = s.arready; assign rvalid = s.rvalid;
  assign rdata = s.rdata; assign rresp = s.rresp;
  assign link.entryStrobe = s.entry; assign link.targetMode = s.target;
  assign link.irqStrobe = s.irq; assign link.pucStrobe = s.power_up_clear;
  assign link.borStrobe = s.bor; assign link.powerCycleStrobe = s.pcyc;
  assign link.converterClkReq = s.periph[0]; assign link.serialClkReq = s.periph[1];
  assign link.cpuClkReq = s.periph[2]; assign link.subsysClkReq = s.periph[3];
  assign link.subsysFreqDiffers = s.periph[4]; assign link.groupAActive = s.periph[5];
  assign link.groupBActive = s.periph[6];
  assign link.regWrite = s.regWrite; assign link.regAddr = s.regAddr;
  assign link.regWdata = s.regWdata;

endmodule : lpeh_host
`default_nettype wire

// ### lpeh_if.sv
// Interface joining controller and host
`timescale 1ns/1ps
`default_nettype none
interface lpeh_if;
  import lpeh_pkg::*;
  // Requests from the far side
  logic entryStrobe; // One-cycle power-mode entry request
  lpeh_mode_t targetMode; // Mode to enter with entryStrobe
  logic irqStrobe; // One-cycle interrupt request
  logic converterClkReq; // Converter asks for the oscillator clock
  logic serialClkReq; // Serial unit asks for the oscillator clock
  logic cpuClkReq; // Processor-started clock request
  logic subsysClkReq; // Subsystem clock is requested/running
  logic subsysFreqDiffers; // Subsystem clock differs from main clock
  logic groupAActive; // A group A peripheral is enabled
  logic groupBActive; // A group B peripheral is enabled
  logic pucStrobe; // Power-up clear (e.g. watchdog)
  logic borStrobe; // Brownout reset
  logic powerCycleStrobe; // Supply removed and restored
  logic regWrite; // One-cycle register write
  logic [1:0] regAddr; // Register index
  logic [15:0] regWdata; // Register write data
  // State reported by the device
  lpeh_mode_t powerMode;
  lpeh_fault_t faultState;
  logic nvmPowered;
  logic debugPullDown;
  logic resetPullUp;

  modport device
  (
    input entryStrobe, targetMode, irqStrobe, converterClkReq, serialClkReq, cpuClkReq,
    input subsysClkReq, subsysFreqDiffers, groupAActive, groupBActive,
    input pucStrobe, borStrobe, powerCycleStrobe, regWrite, regAddr, regWdata,
    output powerMode, faultState, nvmPowered, debugPullDown, resetPullUp
  );

  modport host
  (
    output entryStrobe, targetMode, irqStrobe, converterClkReq, serialClkReq, cpuClkReq,
    output subsysClkReq, subsysFreqDiffers, groupAActive, groupBActive,
    output pucStrobe, borStrobe, powerCycleStrobe, regWrite, regAddr, regWdata,
    input powerMode, faultState, nvmPowered, debugPullDown, resetPullUp
  );
endinterface : lpeh_if
`default_nettype wire

// ### lpeh_pkg.sv
// Shared constants, types and helpers
`default_nettype none
package lpeh_pkg;

  // Power modes of the modelled controller
  typedef enum logic [2:0]
  {
    LPEH_AM    = 3'h0,
    LPEH_LPM0  = 3'h1,
    LPEH_LPM1  = 3'h2,
    LPEH_LPM2  = 3'h3,
    LPEH_LPM3  = 3'h4,
    LPEH_LPM4  = 3'h5,
    LPEH_LPMX5 = 3'h6
  } lpeh_mode_t;

  // Fault condition of the controller
  typedef enum logic [1:0]
  {
    LPEH_RUN       = 2'h0,
    LPEH_LOCK_ONE  = 2'h1,
    LPEH_LOCK_TWO  = 2'h2,
    LPEH_WAKE_HANG = 2'h3
  } lpeh_fault_t;

  // Device-side register indices on the interface register port
  localparam logic [1:0] LPEH_REG_LOCK = 2'h0;
  localparam logic [1:0] LPEH_REG_GENERAL = 2'h1;
  localparam logic [1:0] LPEH_REG_RSTPIN = 2'h2;
  // Field positions
  localparam int LPEH_GEN_PWR_BIT = 0;
  localparam int LPEH_GEN_LPMPWR_BIT = 1;
  localparam int LPEH_RST_RESEN_BIT = 0;
  localparam int LPEH_RST_PULLUP_BIT = 1;
  // Values after reset
  localparam logic [1:0] LPEH_GEN_RESET = 2'h3;
  localparam logic [1:0] LPEH_RSTPIN_RESET = 2'h3;
  // Unlock key in the upper byte of the lock register
  localparam logic [7:0] LPEH_NVM_PASSWORD = 8'hA5;

  // Controller register byte offsets on AXI4-Lite
  localparam logic [3:0] LPEH_AXI_CTRL = 4'h0;
  localparam logic [3:0] LPEH_AXI_PERIPH = 4'h4;
  localparam logic [3:0] LPEH_AXI_NVMWR = 4'h8;
  localparam logic [3:0] LPEH_AXI_STATUS = 4'hC;
  localparam logic [1:0] LPEH_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPEH_RESP_SLVERR = 2'h2;

  // True for the deep modes that carry the entry hazards
  function automatic logic lpeh_is_deep(input lpeh_mode_t m);
    lpeh_is_deep = (m == LPEH_LPM2) || (m == LPEH_LPM3) || (m == LPEH_LPM4);
  endfunction : lpeh_is_deep

endpackage : lpeh_pkg
`default_nettype wire

// ### tb_low_power_entry_hazard_model.sv
// Bench: hazard table, then AXI4-Lite scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_low_power_entry_hazard_model;
  import lpeh_pkg::*;
  typedef struct packed {logic [2:0] pre; logic [2:0] now; lpeh_fault_t exp;} lpeh_row_t; // conv,serial,cpu
  logic clk = 1'b0; // 100 MHz
  logic reset_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, sts;
  logic awready, wready, bvalid, arready, rvalid, exposedA;
  logic [1:0] bresp, rresp, resp;
  lpeh_mode_t modeA;
  lpeh_fault_t faultA, faultB;
  int miscompares = 0, tests_run = 0, cycles = 0;
  // One request toggle per row; the last two rows toggle the processor request
  lpeh_row_t rows [5] = '{'{3'h0, 3'h4, LPEH_LOCK_ONE}, '{3'h0, 3'h2, LPEH_LOCK_ONE},
    '{3'h4, 3'h0, LPEH_LOCK_ONE}, '{3'h0, 3'h1, LPEH_RUN}, '{3'h1, 3'h0, LPEH_RUN}};
  lpeh_if link();
  lpeh_if linkB(); // Second device, driven directly
  logic [2:0] oscB = 3'h0; // Its conv, serial, cpu requests
  assign {linkB.converterClkReq, linkB.serialClkReq, linkB.cpuClkReq} = oscB;

  lpeh_device u_lpeh_device (.clk(clk), .reset_n(reset_n), .link(link), .powerModeOut(modeA),
    .faultOut(faultA), .debugExposed(exposedA));
  lpeh_device u_lpeh_device_b (.clk(clk), .reset_n(reset_n), .link(linkB), .powerModeOut(),
    .faultOut(faultB), .debugExposed());
  lpeh_host u_lpeh_host (.clk(clk), .reset_n(reset_n), .link(link), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  lpeh_asserts u_lpeh_asserts (.clk(clk), .reset_n(reset_n), .entryStrobe(link.entryStrobe),
    .targetMode(link.targetMode), .irqStrobe(link.irqStrobe), .converterClkReq(link.converterClkReq),
    .serialClkReq(link.serialClkReq), .cpuClkReq(link.cpuClkReq), .subsysClkReq(link.subsysClkReq),
    .subsysFreqDiffers(link.subsysFreqDiffers), .groupAActive(link.groupAActive),
    .groupBActive(link.groupBActive), .pucStrobe(link.pucStrobe), .borStrobe(link.borStrobe),
    .powerCycleStrobe(link.powerCycleStrobe), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .powerMode(link.powerMode), .faultState(link.faultState),
    .nvmPowered(link.nvmPowered), .debugPullDown(link.debugPullDown));

  // Clock
  always #5 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task stop_test;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Write: AW and W together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
  endtask : rd

  // Write, then poll status until idle
  task op(input logic [3:0] a, input logic [31:0] d);
    wr(a, d, resp);
    do rd(LPEH_AXI_STATUS, sts, resp); while (sts[0] !== 1'b0);
  endtask : op

  task st(input lpeh_mode_t m, input lpeh_fault_t f);
    chk("mode", 32'(sts[3:1]), 32'(m));
    chk("fault", 32'(sts[5:4]), 32'(f));
  endtask : st

  initial
  begin
    {linkB.entryStrobe, linkB.irqStrobe} = 2'h0;
    {linkB.subsysClkReq, linkB.subsysFreqDiffers, linkB.groupAActive, linkB.groupBActive} = 4'h0;
    {linkB.pucStrobe, linkB.borStrobe, linkB.powerCycleStrobe, linkB.regWrite} = 4'h0;
    linkB.regAddr = 2'h0;
    linkB.regWdata = 16'h0000;
    linkB.targetMode = LPEH_LPM3;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(LPEH_AXI_STATUS, sts, resp);
    chk("status", sts, 32'h000001C0);
    chk("exposed", 32'(exposedA), 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      oscB <= rows[i].pre;
      @(posedge clk);
      oscB <= rows[i].now;
      linkB.entryStrobe <= 1'b1;
      linkB.irqStrobe <= 1'b1;
      @(posedge clk);
      linkB.entryStrobe <= 1'b0;
      linkB.irqStrobe <= 1'b0;
      @(posedge clk);
      chk("hazard", 32'(faultB), 32'(rows[i].exp));
      linkB.pucStrobe <= 1'b1;
      oscB <= 3'h0;
      @(posedge clk);
      linkB.pucStrobe <= 1'b0;
      @(posedge clk);
      chk("recover", 32'(faultB), 32'(LPEH_RUN));
    end
    // Unmapped offsets answer SLVERR
    rd(4'h2, sts, resp);
    chk("rresp", 32'(resp), 32'(LPEH_RESP_SLVERR));
    chk("rdata", sts, 32'h0);
    wr(4'h6, 32'h1, resp);
    chk("bresp", 32'(resp), 32'(LPEH_RESP_SLVERR));
    // Second lockup: clear fails, brownout recovers
    op(LPEH_AXI_PERIPH, 32'h10);
    op(LPEH_AXI_CTRL, 32'h1C);
    chk("lock2", 32'(faultA), 32'(LPEH_LOCK_TWO));
    op(LPEH_AXI_CTRL, 32'h20);
    chk("puc", 32'(sts[5:4]), 32'(LPEH_LOCK_TWO));
    op(LPEH_AXI_CTRL, 32'h40);
    st(LPEH_AM, LPEH_RUN);
    op(LPEH_AXI_PERIPH, 32'h0);
    op(LPEH_AXI_CTRL, 32'h1C);
    chk("samefreq", 32'(sts[5:4]), 32'(LPEH_RUN));
    op(LPEH_AXI_CTRL, 32'h10);
    st(LPEH_AM, LPEH_RUN);
    // Mode 3 wake with one group, then both
    op(LPEH_AXI_PERIPH, 32'h20);
    op(LPEH_AXI_CTRL, 32'h0C);
    st(LPEH_LPM3, LPEH_RUN);
    op(LPEH_AXI_CTRL, 32'h10);
    chk("hang", 32'(sts[5:4]), 32'(LPEH_WAKE_HANG));
    op(LPEH_AXI_CTRL, 32'h80);
    st(LPEH_AM, LPEH_RUN);
    op(LPEH_AXI_PERIPH, 32'h60);
    op(LPEH_AXI_CTRL, 32'h0C);
    op(LPEH_AXI_CTRL, 32'h10);
    st(LPEH_AM, LPEH_RUN);
    // Resistor enable vs debug pull-down
    op(LPEH_AXI_NVMWR, 32'h00020002);
    chk("exposed", 32'(exposedA), 32'h1);
    chk("pulldown", 32'(sts[7]), 32'h0);
    op(LPEH_AXI_NVMWR, 32'h00020003);
    chk("exposed", 32'(exposedA), 32'h0);
    op(LPEH_AXI_CTRL, 32'h100);
    op(LPEH_AXI_NVMWR, 32'h00020002);
    chk("forced", 32'(exposedA), 32'h0);
    // Safe entry: memory idled, mode 3 becomes 2
    op(LPEH_AXI_PERIPH, 32'h20);
    op(LPEH_AXI_CTRL, 32'h10C);
    st(LPEH_LPM2, LPEH_RUN);
    chk("nvmoff", 32'(sts[6]), 32'h0);
    op(LPEH_AXI_CTRL, 32'h110);
    chk("nvmon", 32'(sts[6]), 32'h1);
    op(LPEH_AXI_PERIPH, 32'h10);
    op(LPEH_AXI_CTRL, 32'h11C);
    chk("safe", 32'(sts[5:4]), 32'(LPEH_RUN));
    stop_test();
  end
endmodule : tb_low_power_entry_hazard_model
`default_nettype wire
